// ### hw/bci_regs.svh
// =============================================================
// constants of the boot command interpreter
// =============================================================
// opcodes, answer bytes, lengths and status codes; included by bare name
`ifndef BCI_REGS_SVH
`define BCI_REGS_SVH

// =============================================================
// opcodes
// =============================================================
`define BCI_OP_PING      8'h20
`define BCI_OP_DOWNLOAD  8'h21
`define BCI_OP_RUN       8'h22
`define BCI_OP_STATUS    8'h23
`define BCI_OP_SEND_DATA 8'h24
`define BCI_OP_RESET     8'h25

// =============================================================
// answer bytes and lengths
// =============================================================
`define BCI_ACK          8'hcc
`define BCI_NAK          8'h33
`define BCI_MIN_SIZE     8'h03
`define BCI_REPLY_SIZE   8'h03
`define BCI_DL_DATA_LEN  8'h09
`define BCI_RUN_DATA_LEN 8'h05
`define BCI_REPLY_LAST   2'h2

// =============================================================
// status codes (values arbitrary)
// =============================================================
`define BCI_STAT_OK      8'h01
`define BCI_STAT_UNKNOWN 8'h02
`define BCI_STAT_INVALID 8'h03
`define BCI_STAT_FAIL    8'h04

`endif

// ### hw/bci_pkg.sv
// =============================================================
// types of the boot command interpreter
// =============================================================
// state encodings shared by the interpreter and its framer
package bci_pkg;

	typedef enum logic [2:0] {
		RX_SIZE = 3'b001,
		RX_SUM  = 3'b010,
		RX_DATA = 3'b100
	} bci_rx_state_t;

	typedef enum logic [8:0] {
		ST_IDLE    = 9'b000000001,
		ST_DECODE  = 9'b000000010,
		ST_ERASE   = 9'b000000100,
		ST_PROG    = 9'b000001000,
		ST_ANSWER  = 9'b000010000,
		ST_REPLY   = 9'b000100000,
		ST_HOSTACK = 9'b001000000,
		ST_RUN     = 9'b010000000,
		ST_RESET   = 9'b100000000
	} bci_state_t;

	typedef enum logic [3:0] {
		POST_NONE  = 4'b0001,
		POST_REPLY = 4'b0010,
		POST_RUN   = 4'b0100,
		POST_RESET = 4'b1000
	} bci_post_t;

endpackage

// ### hw/bci_frame_rx.sv
// =============================================================
// packet framer: skips zero padding, counts, sums and checks
// =============================================================
// bytes arrive with valid/ready; accept_i gates intake
`timescale 1ns/1ps
`include "bci_regs.svh"

module bci_frame_rx (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       rx_valid_i,
	input  wire logic [7:0] rx_data_i,
	input  wire logic       accept_i,
	output logic            rx_ready_o,
	output logic            byte_we_o,
	output logic      [7:0] byte_idx_o,
	output logic      [7:0] byte_data_o,
	output logic            pkt_done_o,
	output logic            pkt_ok_o,
	output logic      [7:0] pkt_len_o
);

	bci_pkg::bci_rx_state_t state_q, state_d;
	logic [7:0]             len_q, len_d;
	logic [7:0]             chk_q, chk_d;
	logic [7:0]             acc_q, acc_d;
	logic [7:0]             cnt_q, cnt_d;
	logic                   fire;

	// =============================================================
	// next state
	// =============================================================
	always_comb
	begin
		fire        = rx_valid_i & accept_i;
		rx_ready_o  = accept_i;
		byte_we_o   = 1'b0;
		byte_idx_o  = cnt_q;
		byte_data_o = rx_data_i;
		pkt_done_o  = 1'b0;
		pkt_ok_o    = 1'b0;
		pkt_len_o   = len_q;
		state_d     = state_q;
		len_d       = len_q;
		chk_d       = chk_q;
		acc_d       = acc_q;
		cnt_d       = cnt_q;
		unique case (state_q)
			bci_pkg::RX_SIZE:
			begin
				if (fire && rx_data_i != 8'h00)
				begin
					if (rx_data_i < `BCI_MIN_SIZE)
					begin
						pkt_done_o = 1'b1;
						len_d      = 8'h00;
					end
					else
					begin
						len_d   = rx_data_i - 8'h02;
						state_d = bci_pkg::RX_SUM;
					end
				end
			end
			bci_pkg::RX_SUM:
			begin
				if (fire)
				begin
					chk_d   = rx_data_i;
					acc_d   = 8'h00;
					cnt_d   = 8'h00;
					state_d = bci_pkg::RX_DATA;
				end
			end
			bci_pkg::RX_DATA:
			begin
				if (fire)
				begin
					byte_we_o = 1'b1;
					acc_d     = acc_q + rx_data_i;
					if (cnt_q == len_q - 8'h01)
					begin
						pkt_done_o = 1'b1;
						pkt_ok_o   = (acc_d == chk_q);
						state_d    = bci_pkg::RX_SIZE;
					end
					else
					begin
						cnt_d = cnt_q + 8'h01;
					end
				end
			end
		endcase
	end

	// =============================================================
	// registers
	// =============================================================
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= bci_pkg::RX_SIZE;
			len_q   <= 8'h00;
			chk_q   <= 8'h00;
			acc_q   <= 8'h00;
			cnt_q   <= 8'h00;
		end
		else
		begin
			state_q <= state_d;
			len_q   <= len_d;
			chk_q   <= chk_d;
			acc_q   <= acc_d;
			cnt_q   <= cnt_d;
		end
	end

	// =============================================================
	// checks
	// =============================================================
	zero_pad_skip_a:
	assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_q == bci_pkg::RX_SIZE && fire && rx_data_i == 8'h00) |=> state_q == bci_pkg::RX_SIZE)
	else $error("zero padding started a packet");

endmodule

// ### hw/bci_top.sv
// =============================================================
// boot command interpreter
// =============================================================
// serial bytes in and out by valid/ready; flash erase and program by
// request/done; run and software reset leave as one-cycle pulses
// Operation
// - status query returns last command result
// - status query three bytes; reply one status byte
// - download carries address then count, MSB first
// - download packet is eleven bytes long
// - download erases region before answering
// - each send data continues at next address
// - programming ends when count fully received
// - rejected send data leaves address unchanged
// - run packet seven bytes, one address
// - run acknowledges before transferring control
// - reset packet three bytes, no parameters
// - reset acknowledges before software reset
// - only reset reloads stack pointer by hardware
// - length byte, sum byte, then data bytes
// - answer acknowledge or not-acknowledge byte
// - leading zero bytes are ignored
`timescale 1ns/1ps
`include "bci_regs.svh"

module bci_top (
	input  wire logic        MCLK_I,
	input  wire logic        RESETN_I,
	input  wire logic        RX_VALID_I,
	input  wire logic [7:0]  RX_DATA_I,
	output logic             RX_READY_O,
	output logic             TX_VALID_O,
	output logic      [7:0]  TX_DATA_O,
	input  wire logic        TX_READY_I,
	output logic             ERASE_REQ_O,
	output logic      [31:0] ERASE_ADDR_O,
	output logic      [31:0] ERASE_COUNT_O,
	input  wire logic        ERASE_DONE_I,
	input  wire logic        ERASE_ERR_I,
	output logic             PROG_REQ_O,
	output logic      [31:0] PROG_ADDR_O,
	output logic      [7:0]  PROG_DATA_O,
	input  wire logic        PROG_DONE_I,
	input  wire logic        PROG_ERR_I,
	output logic             RUN_O,
	output logic      [31:0] RUN_ADDR_O,
	output logic             SWRESET_O
);

	logic                rst_meta_q;
	logic                rst_n;
	logic                rx_ready;
	logic                byte_we;
	logic [7:0]          byte_idx;
	logic [7:0]          byte_data;
	logic                pkt_done;
	logic                pkt_ok;
	logic [7:0]          pkt_len;
	logic [7:0]          buf_q [0:252];
	bci_pkg::bci_state_t state_q, state_d;
	bci_pkg::bci_post_t  post_q, post_d;
	logic                ok_q, ok_d;
	logic [7:0]          len_q, len_d;
	logic [7:0]          status_q, status_d;
	logic [31:0]         prog_addr_q, prog_addr_d;
	logic [31:0]         remain_q, remain_d;
	logic                dl_active_q, dl_active_d;
	logic [7:0]          idx_q, idx_d;
	logic [7:0]          prog_data_q, prog_data_d;
	logic [7:0]          tx_byte_q, tx_byte_d;
	logic [31:0]         run_addr_q, run_addr_d;
	logic [7:0]          last_tx_q;
	logic [7:0]          nbytes;
	logic                tx_fire;

	function automatic logic [31:0] be32(input logic [7:0] b3, input logic [7:0] b2,
		input logic [7:0] b1, input logic [7:0] b0);
		be32 = {b3, b2, b1, b0};
	endfunction

	// =============================================================
	// reset release
	// =============================================================
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// =============================================================
	// framer
	// =============================================================
	bci_frame_rx u_frame (
		.clk_i       (MCLK_I),
		.rst_n_i     (rst_n),
		.rx_valid_i  (RX_VALID_I),
		.rx_data_i   (RX_DATA_I),
		.accept_i    (state_q == bci_pkg::ST_IDLE),
		.rx_ready_o  (rx_ready),
		.byte_we_o   (byte_we),
		.byte_idx_o  (byte_idx),
		.byte_data_o (byte_data),
		.pkt_done_o  (pkt_done),
		.pkt_ok_o    (pkt_ok),
		.pkt_len_o   (pkt_len)
	);

	always_ff @(posedge MCLK_I)
	begin
		if (byte_we)
			buf_q[byte_idx] <= byte_data;
	end

	// =============================================================
	// ports
	// =============================================================
	assign RX_READY_O    = rx_ready | (state_q == bci_pkg::ST_HOSTACK);
	assign TX_VALID_O    = (state_q == bci_pkg::ST_ANSWER) | (state_q == bci_pkg::ST_REPLY);
	assign TX_DATA_O     = tx_byte_q;
	assign tx_fire       = TX_VALID_O & TX_READY_I;
	assign ERASE_REQ_O   = (state_q == bci_pkg::ST_ERASE);
	assign ERASE_ADDR_O  = prog_addr_q;
	assign ERASE_COUNT_O = remain_q;
	assign PROG_REQ_O    = (state_q == bci_pkg::ST_PROG);
	assign PROG_ADDR_O   = prog_addr_q;
	assign PROG_DATA_O   = prog_data_q;
	assign RUN_O         = (state_q == bci_pkg::ST_RUN);
	assign RUN_ADDR_O    = run_addr_q;
	assign SWRESET_O     = (state_q == bci_pkg::ST_RESET);
	assign nbytes        = len_q - 8'h01;

	// =============================================================
	// command sequencer
	// =============================================================
	always_comb
	begin
		state_d     = state_q;
		post_d      = post_q;
		ok_d        = ok_q;
		len_d       = len_q;
		status_d    = status_q;
		prog_addr_d = prog_addr_q;
		remain_d    = remain_q;
		dl_active_d = dl_active_q;
		idx_d       = idx_q;
		prog_data_d = prog_data_q;
		tx_byte_d   = tx_byte_q;
		run_addr_d  = run_addr_q;
		unique case (state_q)
			bci_pkg::ST_IDLE:
			begin
				if (pkt_done)
				begin
					ok_d    = pkt_ok;
					len_d   = pkt_len;
					state_d = bci_pkg::ST_DECODE;
				end
			end
			bci_pkg::ST_DECODE:
			begin
				tx_byte_d = `BCI_ACK;
				post_d    = bci_pkg::POST_NONE;
				state_d   = bci_pkg::ST_ANSWER;
				if (!ok_q)
					tx_byte_d = `BCI_NAK;
				else
				begin
					case (buf_q[0])
						`BCI_OP_PING:
							status_d = `BCI_STAT_OK;
						`BCI_OP_STATUS:
							post_d = bci_pkg::POST_REPLY;
						`BCI_OP_DOWNLOAD:
						begin
							dl_active_d = 1'b0;
							prog_addr_d = be32(buf_q[1], buf_q[2], buf_q[3], buf_q[4]);
							remain_d    = be32(buf_q[5], buf_q[6], buf_q[7], buf_q[8]);
							if (len_q != `BCI_DL_DATA_LEN || remain_d == 32'h0)
								status_d = `BCI_STAT_INVALID;
							else
								state_d = bci_pkg::ST_ERASE;
						end
						`BCI_OP_SEND_DATA:
						begin
							if (!dl_active_q || nbytes == 8'h00 || {24'h0, nbytes} > remain_q)
								status_d = `BCI_STAT_INVALID;
							else
							begin
								idx_d       = 8'h01;
								prog_data_d = buf_q[1];
								state_d     = bci_pkg::ST_PROG;
							end
						end
						`BCI_OP_RUN:
						begin
							if (len_q != `BCI_RUN_DATA_LEN)
								status_d = `BCI_STAT_INVALID;
							else
							begin
								run_addr_d = be32(buf_q[1], buf_q[2], buf_q[3], buf_q[4]);
								status_d   = `BCI_STAT_OK;
								post_d     = bci_pkg::POST_RUN;
							end
						end
						`BCI_OP_RESET:
							post_d = bci_pkg::POST_RESET;
						default:
							status_d = `BCI_STAT_UNKNOWN;
					endcase
				end
			end
			bci_pkg::ST_ERASE:
			begin
				if (ERASE_DONE_I)
				begin
					status_d    = ERASE_ERR_I ? `BCI_STAT_FAIL : `BCI_STAT_OK;
					dl_active_d = !ERASE_ERR_I;
					state_d     = bci_pkg::ST_ANSWER;
				end
			end
			bci_pkg::ST_PROG:
			begin
				if (PROG_DONE_I)
				begin
					if (PROG_ERR_I)
					begin
						status_d    = `BCI_STAT_FAIL;
						dl_active_d = 1'b0;
						state_d     = bci_pkg::ST_ANSWER;
					end
					else
					begin
						prog_addr_d = prog_addr_q + 32'h1;
						remain_d    = remain_q - 32'h1;
						if (remain_q == 32'h1)
							dl_active_d = 1'b0;
						if (idx_q == nbytes)
						begin
							status_d = `BCI_STAT_OK;
							state_d  = bci_pkg::ST_ANSWER;
						end
						else
						begin
							idx_d       = idx_q + 8'h01;
							prog_data_d = buf_q[idx_d];
						end
					end
				end
			end
			bci_pkg::ST_ANSWER:
			begin
				if (TX_READY_I)
				begin
					unique case (post_q)
						bci_pkg::POST_NONE:
							state_d = bci_pkg::ST_IDLE;
						bci_pkg::POST_REPLY:
						begin
							tx_byte_d = `BCI_REPLY_SIZE;
							idx_d     = 8'h00;
							state_d   = bci_pkg::ST_REPLY;
						end
						bci_pkg::POST_RUN:
							state_d = bci_pkg::ST_RUN;
						bci_pkg::POST_RESET:
							state_d = bci_pkg::ST_RESET;
					endcase
				end
			end
			bci_pkg::ST_REPLY:
			begin
				if (TX_READY_I)
				begin
					tx_byte_d = status_q;
					idx_d     = idx_q + 8'h01;
					if (idx_q[1:0] == `BCI_REPLY_LAST)
						state_d = bci_pkg::ST_HOSTACK;
				end
			end
			bci_pkg::ST_HOSTACK:
			begin
				if (RX_VALID_I && RX_DATA_I != 8'h00)
					state_d = bci_pkg::ST_IDLE;
			end
			bci_pkg::ST_RUN:
				state_d = bci_pkg::ST_IDLE;
			bci_pkg::ST_RESET:
			begin
				dl_active_d = 1'b0;
				status_d    = `BCI_STAT_OK;
				state_d     = bci_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q     <= bci_pkg::ST_IDLE;
			post_q      <= bci_pkg::POST_NONE;
			ok_q        <= 1'b0;
			len_q       <= 8'h00;
			status_q    <= `BCI_STAT_OK;
			prog_addr_q <= 32'h0;
			remain_q    <= 32'h0;
			dl_active_q <= 1'b0;
			idx_q       <= 8'h00;
			prog_data_q <= 8'h00;
			tx_byte_q   <= 8'h00;
			run_addr_q  <= 32'h0;
			last_tx_q   <= 8'h00;
		end
		else
		begin
			state_q     <= state_d;
			post_q      <= post_d;
			ok_q        <= ok_d;
			len_q       <= len_d;
			status_q    <= status_d;
			prog_addr_q <= prog_addr_d;
			remain_q    <= remain_d;
			dl_active_q <= dl_active_d;
			idx_q       <= idx_d;
			prog_data_q <= prog_data_d;
			tx_byte_q   <= tx_byte_d;
			run_addr_q  <= run_addr_d;
			if (tx_fire)
				last_tx_q <= tx_byte_q;
		end
	end

	// =============================================================
	// checks
	// =============================================================
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!rst_n);

	bad_sum_nak_a:
	assert property ((state_q == bci_pkg::ST_IDLE && pkt_done && !pkt_ok) |-> ##2 (TX_VALID_O && TX_DATA_O == `BCI_NAK))
	else $error("bad checksum not answered with nak");

	erase_before_ack_a:
	assert property (ERASE_REQ_O |-> !TX_VALID_O && !PROG_REQ_O)
	else $error("answer sent during erase");

	nak_keeps_addr_a:
	assert property ((TX_VALID_O && TX_DATA_O == `BCI_NAK) |-> $stable(prog_addr_q) && $stable(remain_q))
	else $error("address moved on nak");

	addr_advance_a:
	assert property ((PROG_REQ_O && PROG_DONE_I && !PROG_ERR_I) |=> prog_addr_q == $past(prog_addr_q) + 32'h1)
	else $error("programming address did not advance");

	count_end_a:
	assert property (dl_active_q |-> remain_q != 32'h0)
	else $error("download still active with nothing left");

	guarded_program_a:
	assert property (PROG_REQ_O |-> dl_active_q)
	else $error("programming without valid setup");

	run_after_ack_a:
	assert property (RUN_O |-> last_tx_q == `BCI_ACK && $past(tx_fire) && !SWRESET_O)
	else $error("run issued before ack");

	reset_after_ack_a:
	assert property (SWRESET_O |-> last_tx_q == `BCI_ACK && $past(tx_fire) && !RUN_O)
	else $error("software reset issued before ack");

	status_reply_a:
	assert property ((state_q == bci_pkg::ST_REPLY && tx_fire && idx_q == 8'h00)
		|=> TX_VALID_O && TX_DATA_O == status_q)
	else $error("status reply carries wrong byte");

endmodule

// ### bench/bci_flash_model.sv
// =============================================================
// flash side model for the boot command interpreter
// =============================================================
// answers erase and program requests wait_i plus one cycles after they rise
// assumes each request is held until its done is seen
`timescale 1ns/1ps

module bci_flash_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       erase_req_i,
	input  wire logic       prog_req_i,
	input  wire logic [7:0] wait_i,
	input  wire logic       fail_i,
	output logic            erase_done_o,
	output logic            erase_err_o,
	output logic            prog_done_o,
	output logic            prog_err_o
);
	logic [7:0] cnt_q;
	logic       busy;
	logic       fin;

	assign busy = (erase_req_i && !erase_done_o) || (prog_req_i && !prog_done_o);
	assign fin  = busy && (cnt_q >= wait_i);

	// error lines are meaningful only beside done; otherwise they show the opposite
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q        <= 8'h00;
			erase_done_o <= 1'b0;
			prog_done_o  <= 1'b0;
			erase_err_o  <= 1'b1;
			prog_err_o   <= 1'b1;
		end
		else
		begin
			cnt_q        <= fin ? 8'h00 : (busy ? cnt_q + 8'h01 : 8'h00);
			erase_done_o <= fin && erase_req_i;
			prog_done_o  <= fin && prog_req_i;
			erase_err_o  <= fin ? fail_i : !fail_i;
			prog_err_o   <= fin ? fail_i : !fail_i;
		end
	end
endmodule

// ### bench/bci_top_tb.sv
// =============================================================
// testbench of the boot command interpreter
// =============================================================
// the bench plays the host; bci_flash_model answers flash requests
`timescale 1ns/1ps
`include "bci_regs.svh"

module bci_top_tb;
	logic        MCLK_I, RESETN_I, RX_VALID_I, TX_READY_I, fail_q;
	logic [7:0]  RX_DATA_I, wait_q;
	logic        RX_READY_O, TX_VALID_O, ERASE_REQ_O, PROG_REQ_O, RUN_O, SWRESET_O;
	logic        ERASE_DONE_I, ERASE_ERR_I, PROG_DONE_I, PROG_ERR_I;
	logic [7:0]  TX_DATA_O, PROG_DATA_O;
	logic [31:0] ERASE_ADDR_O, ERASE_COUNT_O, PROG_ADDR_O, RUN_ADDR_O;
	int          num_errors, n_tests, cyc, n_run, n_sw, tx_at, run_at, sw_at, ed_at;
	logic [31:0] pa[$];
	logic [7:0]  pd[$];

	bci_top bci_top_inst (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .RX_VALID_I(RX_VALID_I),
		.RX_DATA_I(RX_DATA_I), .RX_READY_O(RX_READY_O), .TX_VALID_O(TX_VALID_O),
		.TX_DATA_O(TX_DATA_O), .TX_READY_I(TX_READY_I), .ERASE_REQ_O(ERASE_REQ_O),
		.ERASE_ADDR_O(ERASE_ADDR_O), .ERASE_COUNT_O(ERASE_COUNT_O), .ERASE_DONE_I(ERASE_DONE_I),
		.ERASE_ERR_I(ERASE_ERR_I), .PROG_REQ_O(PROG_REQ_O), .PROG_ADDR_O(PROG_ADDR_O),
		.PROG_DATA_O(PROG_DATA_O), .PROG_DONE_I(PROG_DONE_I), .PROG_ERR_I(PROG_ERR_I),
		.RUN_O(RUN_O), .RUN_ADDR_O(RUN_ADDR_O), .SWRESET_O(SWRESET_O));

	bci_flash_model bci_flash_model_inst (.clk_i(MCLK_I), .rst_n_i(RESETN_I),
		.erase_req_i(ERASE_REQ_O), .prog_req_i(PROG_REQ_O), .wait_i(wait_q), .fail_i(fail_q),
		.erase_done_o(ERASE_DONE_I), .erase_err_o(ERASE_ERR_I),
		.prog_done_o(PROG_DONE_I), .prog_err_o(PROG_ERR_I));

	initial
	begin
		MCLK_I = 1'b0;
		forever #50 MCLK_I = ~MCLK_I;
	end

	// =============================================================
	// monitors and timeout
	// =============================================================
	always @(posedge MCLK_I)
	begin
		cyc <= cyc + 1;
		if (TX_VALID_O === 1'b1 && TX_READY_I === 1'b1) tx_at <= cyc;
		if (RUN_O === 1'b1)
		begin
			n_run  <= n_run + 1;
			run_at <= cyc;
		end
		if (SWRESET_O === 1'b1)
		begin
			n_sw  <= n_sw + 1;
			sw_at <= cyc;
		end
		if (ERASE_DONE_I === 1'b1) ed_at <= cyc;
		if (PROG_REQ_O === 1'b1 && PROG_DONE_I === 1'b1)
		begin
			pa.push_back(PROG_ADDR_O);
			pd.push_back(PROG_DATA_O);
		end
		if (cyc == 20000)
		begin
			num_errors++;
			close_out;
		end
	end

	// =============================================================
	// shared tasks
	// =============================================================
	task close_out;
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk_b(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task chk_w(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// holds the byte until an edge that sees ready high
	task put_byte(input logic [7:0] b);
		logic ok;
		@(negedge MCLK_I);
		RX_VALID_I = 1'b1;
		RX_DATA_I  = b;
		TX_READY_I = 1'b0;
		#1 ok = RX_READY_O;
		@(posedge MCLK_I);
		while (ok !== 1'b1)
		begin
			#1 ok = RX_READY_O;
			@(posedge MCLK_I);
		end
	endtask

	task rx_idle;
		@(negedge MCLK_I);
		RX_VALID_I = 1'b0;
		RX_DATA_I  = ~RX_DATA_I;
	endtask

	// ready is held low through the stall so no byte slips past unseen
	task get_byte(input int st, output logic [7:0] b);
		logic ok;
		@(negedge MCLK_I);
		TX_READY_I = 1'b0;
		repeat (st) @(negedge MCLK_I);
		@(negedge MCLK_I);
		TX_READY_I = 1'b1;
		#1 ok = TX_VALID_O;
		b = TX_DATA_O;
		@(posedge MCLK_I);
		while (ok !== 1'b1)
		begin
			#1 ok = TX_VALID_O;
			b = TX_DATA_O;
			@(posedge MCLK_I);
		end
	endtask

	// n data bytes: opcode, then w0 and w1 most significant byte first
	task cmd(input logic [7:0] op, input logic [31:0] w0, input logic [31:0] w1, input int n,
		input logic bad, input logic [7:0] ans, input int st);
		logic [7:0] d[9];
		logic [7:0] s;
		logic [7:0] b;
		int         i;
		d = '{op, w0[31:24], w0[23:16], w0[15:8], w0[7:0], w1[31:24], w1[23:16], w1[15:8], w1[7:0]};
		s = 8'h00;
		for (i = 0; i < n; i++) s = s + d[i];
		put_byte(8'h00);
		put_byte(8'h00);
		put_byte(n[7:0] + 8'h02);
		put_byte(bad ? s + 8'h01 : s);
		for (i = 0; i < n; i++) put_byte(d[i]);
		rx_idle;
		get_byte(st, b);
		chk_b(b, ans, "answer byte");
	endtask

	task status(input logic [7:0] exp);
		logic [7:0] b;
		cmd(`BCI_OP_STATUS, 32'h0, 32'h0, 1, 1'b0, `BCI_ACK, 0);
		get_byte(0, b);
		chk_b(b, `BCI_REPLY_SIZE, "reply length");
		get_byte(1, b);
		chk_b(b, exp, "reply sum");
		get_byte(0, b);
		chk_b(b, exp, "status code");
		put_byte(8'h00);
		put_byte(`BCI_ACK);
		rx_idle;
	endtask

	// =============================================================
	// scenarios
	// =============================================================
	task t_ping_status;
		cmd(`BCI_OP_PING, 32'h0, 32'h0, 1, 1'b0, `BCI_ACK, 0);
		status(`BCI_STAT_OK);
	endtask

	task t_orphan_data;
		cmd(`BCI_OP_SEND_DATA, 32'h11223344, 32'h0, 5, 1'b0, `BCI_ACK, 0);
		status(`BCI_STAT_INVALID);
		chk_w(pa.size(), 32'd0, "nothing programmed");
	endtask

	task t_bad_sum;
		cmd(`BCI_OP_PING, 32'h0, 32'h0, 1, 1'b1, `BCI_NAK, 0);
		status(`BCI_STAT_INVALID);
	endtask

	task t_download;
		@(negedge MCLK_I) wait_q = 8'h06;
		cmd(`BCI_OP_DOWNLOAD, 32'h00002000, 32'h00000006, 9, 1'b0, `BCI_ACK, 3);
		chk_w(ERASE_ADDR_O, 32'h00002000, "erase address");
		chk_w(ERASE_COUNT_O, 32'h00000006, "erase count");
		@(negedge MCLK_I);
		chk_b({7'h0, tx_at > ed_at}, 8'h01, "answer after erase");
		status(`BCI_STAT_OK);
	endtask

	task t_send;
		logic [7:0] e[6];
		int         i;
		e = '{8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'hb1, 8'hb2};
		@(negedge MCLK_I) wait_q = 8'h02;
		cmd(`BCI_OP_SEND_DATA, 32'ha1a2a3a4, 32'h0, 5, 1'b0, `BCI_ACK, 0);
		cmd(`BCI_OP_SEND_DATA, 32'hb1b20000, 32'h0, 3, 1'b1, `BCI_NAK, 0);
		chk_w(pa.size(), 32'd4, "no write on rejected data");
		cmd(`BCI_OP_SEND_DATA, 32'hb1b20000, 32'h0, 3, 1'b0, `BCI_ACK, 2);
		status(`BCI_STAT_OK);
		for (i = 0; i < 6; i++)
		begin
			chk_w(pa[i], 32'h00002000 + i, "program address");
			chk_b(pd[i], e[i], "program data");
		end
		cmd(`BCI_OP_SEND_DATA, 32'hc1000000, 32'h0, 2, 1'b0, `BCI_ACK, 0);
		status(`BCI_STAT_INVALID);
		chk_w(pa.size(), 32'd6, "nothing past the count");
	endtask

	task t_prog_fail;
		cmd(`BCI_OP_DOWNLOAD, 32'h00003000, 32'h00000004, 9, 1'b0, `BCI_ACK, 0);
		@(negedge MCLK_I) fail_q = 1'b1;
		cmd(`BCI_OP_SEND_DATA, 32'h01020304, 32'h0, 5, 1'b0, `BCI_ACK, 0);
		@(negedge MCLK_I) fail_q = 1'b0;
		status(`BCI_STAT_FAIL);
	endtask

	task t_run;
		cmd(`BCI_OP_RUN, 32'h00002001, 32'h0, 5, 1'b0, `BCI_ACK, 0);
		repeat (3) @(posedge MCLK_I);
		chk_w(RUN_ADDR_O, 32'h00002001, "run address");
		chk_w(run_at - tx_at, 32'd1, "run after answer");
		chk_w(n_run, 32'd1, "one run pulse");
		chk_w(n_sw, 32'd0, "run does no reset");
	endtask

	task t_reset;
		cmd(`BCI_OP_RESET, 32'h0, 32'h0, 1, 1'b0, `BCI_ACK, 0);
		repeat (3) @(posedge MCLK_I);
		chk_w(sw_at - tx_at, 32'd1, "reset after answer");
		chk_w(n_sw, 32'd1, "one reset pulse");
		chk_w(n_run, 32'd1, "reset does no run");
		status(`BCI_STAT_OK);
	endtask

	// =============================================================
	// main sequence
	// =============================================================
	initial
	begin
		RESETN_I   = 1'b0;
		RX_VALID_I = 1'b0;
		RX_DATA_I  = 8'h00;
		TX_READY_I = 1'b0;
		wait_q     = 8'h00;
		fail_q     = 1'b0;
		num_errors = 0;
		n_tests    = 0;
		cyc        = 0;
		n_run      = 0;
		n_sw       = 0;
		repeat (20) @(negedge MCLK_I);
		RESETN_I = 1'b1;
		repeat (4) @(negedge MCLK_I);
		t_ping_status;
		t_orphan_data;
		t_bad_sum;
		t_download;
		t_send;
		t_prog_fail;
		t_run;
		t_reset;
		close_out;
	end
endmodule
